// ===== src/dram_cfg_map.svh
// Constants for the mode configuration link: encodings, fields and timings
//
// Contract
// - AUTO_SELFREFRESH_ENABLE off: refresh rate from range bit
// - AUTO_SELFREFRESH_ENABLE on: thermal sensor sets rate
// - Range bit: 0 normal, 1 extended
// - Write termination taken from MR2 A10:A9
// - Write leveling: nominal termination only
// - MR3 written with BA 011, command MRS
// - MR3 reserved BA2, A3-A12 driven zero
// - Pattern location ignored when A2 zero
// - Pattern enable needs precharged idle, tRP
// - Pattern mode reads return calibration pattern
// - Pattern mode: reads or MRS only
// - NOP leaves ongoing work untouched
// - Deselect executes nothing new
// - MR1 A0 one disables DLL until cleared
// - DLL off: CL 6, CWL 6
// - DLL off: strobe at AL+CL-1
// - DLL off: only refresh interval binds
// - DLL off sequence order and waits
// - After exit hold CKE high, ODT low
// - DLL on: A0 zero, tMRD, DLL reset
// - Hold CKE, ODT until tDLLK passes
// - Long calibration adds tZQoper wait
// - DLL reset bit clears itself
`ifndef DRAM_CFG_MAP_SVH
`define DRAM_CFG_MAP_SVH
`define CMD_MRS      3'h0
`define CMD_REF      3'h1
`define CMD_PRE      3'h2
`define CMD_ACT      3'h3
`define CMD_WR       3'h4
`define CMD_RD       3'h5
`define CMD_NOP      3'h7
`define MR_SEL_0     2'h0
`define MR_SEL_1     2'h1
`define MR_SEL_2     2'h2
`define MR_SEL_3     2'h3
`define MR0_DLL_RST  8
`define MR1_DLL_OFF  0
`define MR1_WLEVEL   7
`define MR2_CWL_LO   3
`define MR2_ASR      6
`define MR2_SRT      7
`define MR2_RTTWR_LO 9
`define MR3_PAT_EN   2
`define CL_DLL_OFF   4'h6
`define CWL_DLL_OFF  4'h6
`define MR0_CL_LO    4
`define CLK_PERIOD_PS 4000
`define T_MOD_PS     15000
`define T_MRD_PS     16000
`define T_RP_PS      13750
`define T_DLLK_CK    512
`define T_ZQOPER_CK  256
`define T_XS_PS      170000
`define CYC(ps) (((ps) + `CLK_PERIOD_PS - 1) / `CLK_PERIOD_PS)
`endif

// ===== src/dram_cfg_pkg.sv
// Types for the mode configuration link: refresh rates for the device end, states for the controller end
package dram_cfg_pkg;
  typedef enum logic [1:0] {
    SR_NORMAL   = 2'h0,
    SR_EXTENDED = 2'h1,
    SR_SENSOR   = 2'h2
  } sr_rate_t;
  typedef enum logic [3:0] {
    CS_IDLE     = 4'h0,
    CS_CMD      = 4'h1,
    CS_WAIT     = 4'h2,
    CS_OFF_MR1  = 4'h3,
    CS_OFF_SRE  = 4'h4,
    CS_OFF_SRX  = 4'h5,
    CS_OFF_MR   = 4'h6,
    CS_ON_SRE   = 4'h7,
    CS_ON_SRX   = 4'h8,
    CS_ON_MR1   = 4'h9,
    CS_ON_RST   = 4'ha,
    CS_ON_MR    = 4'hb,
    CS_LOCK     = 4'hc
  } ctl_state_t;
endpackage

// ===== src/dram_cmd_if.sv
// Command link between the controller end and the device end
`timescale 1ns/10ps
`default_nettype none
interface dram_cmd_if;
  logic        cs_n;
  logic        ras_n;
  logic        cas_n;
  logic        we_n;
  logic [2:0]  ba;
  logic [12:0] addr;
  logic        cke;
  logic        odt;
  logic        rd_valid;
  logic [7:0]  rd_data;
  modport ctl (output cs_n, ras_n, cas_n, we_n, ba, addr, cke, odt,
               input rd_valid, rd_data);
  modport dev (input cs_n, ras_n, cas_n, we_n, ba, addr, cke, odt,
               output rd_valid, rd_data);
endinterface
`default_nettype wire

// ===== src/dram_cfg_device.sv
// Device end: mode registers, pattern mode, DLL state, refresh rate
`timescale 1ns/10ps
`default_nettype none
`include "dram_cfg_map.svh"
module dram_cfg_device (
  input  wire logic         sys_clk,
  input  wire logic         reset_n,
  input  wire logic         clk_en,
  dram_cmd_if.dev           link,
  input  wire logic         thermal_hot,
  output logic [1:0]        sr_rate,
  output logic [1:0]        write_term,
  output logic              dll_enabled,
  output logic              pattern_mode,
  output logic              self_refresh,
  output logic              cmd_seen
);
  localparam logic [7:0] CAL_PATTERN = 8'h55;
  logic [12:0] mr0, mr1, mr2, mr3;
  logic [3:0]  rd_pipe;
  wire selected = ~link.cs_n;
  wire is_nop = selected & link.ras_n & link.cas_n & link.we_n;
  wire is_mrs = selected & ~link.ras_n & ~link.cas_n & ~link.we_n
              & link.cke & ~link.ba[2];
  wire is_rd  = selected & link.ras_n & ~link.cas_n & link.we_n
              & link.cke;
  wire is_sre = selected & ~link.ras_n & ~link.cas_n & link.we_n
              & ~link.cke & ~self_refresh;
  wire sr_exit = self_refresh & link.cke;
  wire [1:0] mr_sel = link.ba[1:0];
  wire dll_off = mr1[`MR1_DLL_OFF];
  wire [3:0] cl = {1'b0, mr0[`MR0_CL_LO+2:`MR0_CL_LO]} + 4'h4;
  // DLL off shortens the strobe reference by one clock
  wire [3:0] rd_lat = dll_off ? cl - 4'h1 : cl;
  wire pat_on = mr3[`MR3_PAT_EN];
  wire [1:0] next_sr_rate = mr2[`MR2_ASR]
    ? (thermal_hot ? 2'(dram_cfg_pkg::SR_EXTENDED)
                   : 2'(dram_cfg_pkg::SR_NORMAL))
    : (mr2[`MR2_SRT] ? 2'(dram_cfg_pkg::SR_EXTENDED)
                     : 2'(dram_cfg_pkg::SR_NORMAL));
  // Write leveling suppresses dynamic write termination
  wire [1:0] next_write_term = mr1[`MR1_WLEVEL] ? 2'h0
                             : mr2[`MR2_RTTWR_LO+1:`MR2_RTTWR_LO];
  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      mr0 <= 13'h0;
      mr1 <= 13'h0;
      mr2 <= 13'h0;
      mr3 <= 13'h0;
    end else if (clk_en) begin
      if (is_mrs) begin
        case (mr_sel)
          `MR_SEL_0: mr0 <= link.addr;
          `MR_SEL_1: mr1 <= link.addr;
          `MR_SEL_2: mr2 <= link.addr;
          default:   mr3 <= link.addr;
        endcase
      end else if (mr0[`MR0_DLL_RST]) begin
        mr0[`MR0_DLL_RST] <= 1'b0;
      end
    end
  end
  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      rd_pipe      <= 4'h0;
      link.rd_valid <= 1'b0;
      link.rd_data  <= 8'h00;
      self_refresh <= 1'b0;
      cmd_seen     <= 1'b0;
      sr_rate      <= 2'h0;
      write_term   <= 2'h0;
      dll_enabled  <= 1'b1;
      pattern_mode <= 1'b0;
    end else if (clk_en) begin
      sr_rate      <= next_sr_rate;
      write_term   <= next_write_term;
      dll_enabled  <= ~dll_off;
      pattern_mode <= pat_on;
      cmd_seen     <= selected & ~is_nop;
      if (is_sre)
        self_refresh <= 1'b1;
      else if (sr_exit)
        self_refresh <= 1'b0;
      if (is_rd)
        rd_pipe <= rd_lat;
      else if (rd_pipe != 4'h0)
        rd_pipe <= rd_pipe - 4'h1;
      link.rd_valid <= (rd_pipe == 4'h1);
      // Array data is not modelled; only the pattern source is real
      link.rd_data  <= (rd_pipe == 4'h1 && pat_on) ? CAL_PATTERN
                                                   : 8'h00;
    end
  end
endmodule
`default_nettype wire

// ===== src/dram_cfg_controller.sv
// Controller end: command issue, pattern guard, DLL switching sequences
`timescale 1ns/10ps
`default_nettype none
`include "dram_cfg_map.svh"
module dram_cfg_controller (
  input  wire logic         sys_clk,
  input  wire logic         reset_n,
  input  wire logic         clk_en,
  dram_cmd_if.ctl           link,
  input  wire logic         req_valid,
  input  wire logic [2:0]   req_cmd,
  input  wire logic [2:0]   req_ba,
  input  wire logic [12:0]  req_addr,
  input  wire logic         dll_off_req,
  input  wire logic         dll_on_req,
  input  wire logic         zq_long,
  output logic              req_ready,
  output logic              req_refused,
  output logic              busy
);
  // Waits round up to whole clocks so no timing is cut short
  localparam int MOD_CYC  = `CYC(`T_MOD_PS);
  localparam int MRD_CYC  = `CYC(`T_MRD_PS);
  localparam int RP_CYC   = `CYC(`T_RP_PS);
  localparam int XS_CYC   = `CYC(`T_XS_PS);
  localparam int DLLK_CYC = `T_DLLK_CK + `T_ZQOPER_CK;

  dram_cfg_pkg::ctl_state_t state, next_state;
  // One down-counter times every gap; ten bits hold the longest lock wait
  logic [9:0]  wait_cnt;
  logic        pat_active;
  logic        term_on;
  // A long calibration is remembered until the next DLL-on lock wait
  logic        zq_pend;

  wire is_mr3  = req_cmd == `CMD_MRS && req_ba[1:0] == `MR_SEL_3;
  // Pattern mode lets through reads and the MRS that may leave it
  wire blocked = pat_active & ~(req_cmd == `CMD_RD || is_mr3);
  wire wait_done = wait_cnt == 10'h0;
  wire take = req_valid & req_ready & ~blocked;
  // Reserved MR3 bits forced low whatever the caller sends
  wire [12:0] mr3_addr = {10'h000, req_addr[2:0]};
  wire [12:0] out_addr = is_mr3 ? mr3_addr : req_addr;
  wire [2:0]  out_ba   = is_mr3 ? 3'h3 : req_ba;

  always_comb begin
    next_state = state;
    case (state)
      dram_cfg_pkg::CS_IDLE: begin
        if (dll_off_req)
          next_state = dram_cfg_pkg::CS_OFF_MR1;
        else if (dll_on_req)
          next_state = dram_cfg_pkg::CS_ON_SRE;
        else if (take)
          next_state = dram_cfg_pkg::CS_WAIT;
      end
      dram_cfg_pkg::CS_WAIT:
        if (wait_done) next_state = dram_cfg_pkg::CS_IDLE;
      // Off sequence: MR1 A0, self refresh, exit, latencies
      dram_cfg_pkg::CS_OFF_MR1:
        next_state = dram_cfg_pkg::CS_OFF_SRE;
      dram_cfg_pkg::CS_OFF_SRE:
        if (wait_done) next_state = dram_cfg_pkg::CS_OFF_SRX;
      dram_cfg_pkg::CS_OFF_SRX:
        if (wait_done) next_state = dram_cfg_pkg::CS_OFF_MR;
      dram_cfg_pkg::CS_OFF_MR:
        if (wait_done) next_state = dram_cfg_pkg::CS_CMD;
      // Second latency write of the off sequence
      dram_cfg_pkg::CS_CMD:
        if (wait_done) next_state = dram_cfg_pkg::CS_WAIT;
      // On sequence: self refresh, exit, MR1 A0 clear, DLL reset, lock
      dram_cfg_pkg::CS_ON_SRE:
        if (wait_done) next_state = dram_cfg_pkg::CS_ON_SRX;
      dram_cfg_pkg::CS_ON_SRX:
        if (wait_done) next_state = dram_cfg_pkg::CS_ON_MR1;
      dram_cfg_pkg::CS_ON_MR1:
        if (wait_done) next_state = dram_cfg_pkg::CS_ON_RST;
      dram_cfg_pkg::CS_ON_RST:
        if (wait_done) next_state = dram_cfg_pkg::CS_ON_MR;
      dram_cfg_pkg::CS_ON_MR:
        if (wait_done) next_state = dram_cfg_pkg::CS_LOCK;
      // Lock wait covers tDLLK, plus tZQoper after a long calibration
      dram_cfg_pkg::CS_LOCK:
        if (wait_done) next_state = dram_cfg_pkg::CS_IDLE;
      default: next_state = dram_cfg_pkg::CS_IDLE;
    endcase
  end

  task automatic drive(input logic [3:0] c, input logic [2:0] b,
                       input logic [12:0] a);
    {link.cs_n, link.ras_n, link.cas_n, link.we_n} <= c;
    link.ba   <= b;
    link.addr <= a;
  endtask

  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      state       <= dram_cfg_pkg::CS_IDLE;
      wait_cnt    <= 10'h0;
      pat_active  <= 1'b0;
      term_on     <= 1'b0;
      zq_pend     <= 1'b0;
      link.cs_n   <= 1'b1;
      link.ras_n  <= 1'b1;
      link.cas_n  <= 1'b1;
      link.we_n   <= 1'b1;
      link.ba     <= 3'h0;
      link.addr   <= 13'h0;
      link.cke    <= 1'b1;
      link.odt    <= 1'b0;
      req_ready   <= 1'b0;
      req_refused <= 1'b0;
      busy        <= 1'b0;
    end else if (clk_en) begin
      state       <= next_state;
      req_ready   <= next_state == dram_cfg_pkg::CS_IDLE;
      busy        <= next_state != dram_cfg_pkg::CS_IDLE;
      req_refused <= req_valid & req_ready & blocked;
      zq_pend     <= zq_long ? 1'b1 : zq_pend;
      if (wait_cnt != 10'h0)
        wait_cnt <= wait_cnt - 10'h1;
      drive(4'hf, 3'h0, 13'h0);
      // ODT held low through every sequence; only idle writes may raise it
      link.odt <= 1'b0;
      case (state)
        dram_cfg_pkg::CS_IDLE: begin
          if (dll_off_req) begin
            term_on <= 1'b0;
          end else if (!dll_on_req && take) begin
            drive({1'b0, req_cmd}, out_ba, out_addr);
            link.odt <= term_on & (req_cmd == `CMD_WR);
            // Write strobe only when MR2 asked for dynamic termination
            if (req_cmd == `CMD_MRS && req_ba[1:0] == `MR_SEL_2)
              term_on <= |req_addr[`MR2_RTTWR_LO+1:`MR2_RTTWR_LO];
            if (is_mr3) begin
              pat_active <= req_addr[`MR3_PAT_EN];
              wait_cnt   <= 10'(RP_CYC > MOD_CYC ? RP_CYC : MOD_CYC);
            end else begin
              wait_cnt <= 10'(MOD_CYC);
            end
          end
        end
        dram_cfg_pkg::CS_OFF_MR1: begin
          // MR1 A0 set: the device runs without its DLL from here on
          drive({1'b0, `CMD_MRS}, {1'b0, `MR_SEL_1}, 13'h0001);
          wait_cnt <= 10'(MOD_CYC);
        end
        dram_cfg_pkg::CS_OFF_SRE, dram_cfg_pkg::CS_ON_SRE:
          if (wait_done) begin
            // Self refresh keeps the rows alive while the clock is slowed
            drive({1'b0, `CMD_REF}, 3'h0, 13'h0);
            link.cke <= 1'b0;
            wait_cnt <= 10'(XS_CYC);
          end
        dram_cfg_pkg::CS_OFF_SRX, dram_cfg_pkg::CS_ON_SRX:
          if (wait_done) begin
            link.cke <= 1'b1;
            wait_cnt <= 10'(XS_CYC);
          end
        dram_cfg_pkg::CS_OFF_MR:
          // Latencies are rewritten only once tXS has run out
          if (wait_done) begin
            // CL field 2 gives 6 with the +4 offset
            drive({1'b0, `CMD_MRS}, {1'b0, `MR_SEL_0}, 13'h0020);
            wait_cnt <= 10'(MRD_CYC);
          end
        dram_cfg_pkg::CS_CMD:
          if (wait_done) begin
            // CWL field 1 gives 6
            drive({1'b0, `CMD_MRS}, {1'b0, `MR_SEL_2},
                  13'(1 << `MR2_CWL_LO));
            wait_cnt <= 10'(MOD_CYC);
          end
        dram_cfg_pkg::CS_ON_MR1:
          if (wait_done) begin
            drive({1'b0, `CMD_MRS}, {1'b0, `MR_SEL_1}, 13'h0000);
            wait_cnt <= 10'(MRD_CYC);
          end
        dram_cfg_pkg::CS_ON_RST:
          if (wait_done) begin
            // The device clears the reset bit itself; no second write
            drive({1'b0, `CMD_MRS}, {1'b0, `MR_SEL_0},
                  13'(1 << `MR0_DLL_RST));
            wait_cnt <= 10'(MRD_CYC);
          end
        dram_cfg_pkg::CS_ON_MR:
          if (wait_done) begin
            // Back to the default write latency before the lock wait
            drive({1'b0, `CMD_MRS}, {1'b0, `MR_SEL_2}, 13'h0000);
            wait_cnt <= zq_pend ? 10'(DLLK_CYC)
                                : 10'(`T_DLLK_CK);
            // A request arriving now is kept for the next switch
            zq_pend  <= zq_long;
          end
        default: ;
      endcase
    end
  end
endmodule
`default_nettype wire

// ===== tb/dram_cfg_monitor.sv
// Checker watching the command link between the two ends
`timescale 1ns/10ps
`default_nettype none
module dram_cfg_monitor (
  input wire logic        sys_clk,
  input wire logic        reset_n,
  input wire logic        cs_n,
  input wire logic        ras_n,
  input wire logic        cas_n,
  input wire logic        we_n,
  input wire logic [2:0]  ba,
  input wire logic [12:0] addr,
  input wire logic        cke,
  input wire logic        odt,
  input wire logic        rd_valid,
  input wire logic [7:0]  rd_data
);
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!reset_n);
  logic       pat;
  wire  [2:0] cmd = {ras_n, cas_n, we_n};
  wire        sel = !cs_n && cmd != 3'h7;
  wire        mrs = sel && cmd == 3'h0;
  wire        mr3 = mrs && ba[1:0] == 2'h3;
  // Shadow of pattern mode, so the command filter can be judged
  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n)
      pat <= 1'b0;
    else if (mr3)
      pat <= addr[2];
  end
  sequence s_sre; sel && cmd == 3'h1 && !cke; endsequence
  sequence s_srx; $rose(cke); endsequence
  property p_mr3_resv;
    mr3 |-> ba[2] == 1'b0 && addr[12:3] == 10'h0;
  endproperty
  a_mr3_resv: assert property (p_mr3_resv) else $error("mr3 reserved");
  property p_space; sel |=> cs_n [*3]; endproperty
  a_space: assert property (p_space) else $error("command spacing");
  property p_odt; odt |-> sel && cmd == 3'h4; endproperty
  a_odt: assert property (p_odt) else $error("odt high");
  property p_mrs_cke; mrs |-> cke; endproperty
  a_mrs_cke: assert property (p_mrs_cke) else $error("mrs cke low");
  property p_pat_only;
    pat && sel |-> cmd == 3'h5 || mr3;
  endproperty
  a_pat_only: assert property (p_pat_only) else $error("pattern cmd");
  property p_rd_lat; sel && cmd == 3'h5 |-> ##[2:14] rd_valid; endproperty
  a_rd_lat: assert property (p_rd_lat) else $error("read latency");
  property p_sre; s_sre |=> !cke [*3]; endproperty
  a_sre: assert property (p_sre) else $error("self refresh entry");
  property p_srx; s_srx |-> (cke && cs_n) [*8]; endproperty
  a_srx: assert property (p_srx) else $error("self refresh exit");
endmodule
`default_nettype wire

// ===== tb/dram_mode_config_dll_switch_tb.sv
// Bench joining controller and device ends, with a link checker
`timescale 1ns/10ps
`default_nettype none
`include "dram_cfg_map.svh"
module dram_mode_config_dll_switch_tb;
  logic        sys_clk = 1'b0;
  logic        reset_n = 1'b0;
  logic        clk_en = 1'b1;
  logic        thermal_hot = 1'b0;
  logic        req_valid, dll_off_req, dll_on_req, zq_long;
  logic [2:0]  req_cmd, req_ba;
  logic [12:0] req_addr;
  logic        req_ready, req_refused, busy;
  logic [1:0]  sr_rate, write_term;
  logic        dll_enabled, pattern_mode, self_refresh, cmd_seen;
  int          error_cnt = 0;
  int          samples_checked = 0;
  logic [31:0] rnd = 32'ha505;
  dram_cmd_if link ();
  dram_cfg_device dram_cfg_device_inst (.sys_clk, .reset_n, .clk_en,
    .link(link), .thermal_hot, .sr_rate, .write_term, .dll_enabled,
    .pattern_mode, .self_refresh, .cmd_seen);
  dram_cfg_controller dram_cfg_controller_inst (.sys_clk, .reset_n,
    .clk_en, .link(link), .req_valid, .req_cmd, .req_ba, .req_addr,
    .dll_off_req, .dll_on_req, .zq_long, .req_ready, .req_refused,
    .busy);
  dram_cfg_monitor dram_cfg_monitor_inst (.sys_clk, .reset_n,
    .cs_n(link.cs_n), .ras_n(link.ras_n), .cas_n(link.cas_n),
    .we_n(link.we_n), .ba(link.ba), .addr(link.addr), .cke(link.cke),
    .odt(link.odt), .rd_valid(link.rd_valid), .rd_data(link.rd_data));
  always #2 sys_clk = ~sys_clk;
  function automatic logic [31:0] lfsr(input logic [31:0] v);
    return {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
  endfunction
  task automatic results();
    $display("checks %0d mismatches %0d", samples_checked, error_cnt);
    if (error_cnt == 0 && samples_checked > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask
  task automatic chk(input logic ok, input string m);
    samples_checked++;
    if (ok !== 1'b1) begin
      error_cnt++;
      $display("CHECK FAILED t=%0t %s", $time, m);
    end
  endtask
  task automatic step(); @(posedge sys_clk); #1; endtask
  task automatic rdy();
    for (int n = 0; n < 200 && req_ready !== 1'b1; n++) step();
  endtask
  // Returns just after the edge that takes the request
  task automatic req(input logic [2:0] c, b, input logic [12:0] a);
    rdy();
    {req_valid, req_cmd, req_ba, req_addr} = {1'b1, c, b, a};
    step();
    req_valid = 1'b0;
  endtask
  task automatic rd(output int lat, output logic [7:0] d);
    req(3'h5, 3'h0, 13'h0);
    for (lat = 0; lat < 30 && link.rd_valid !== 1'b1; lat++) step();
    d = link.rd_data;
  endtask
  task automatic watch(ref logic s, output logic seen);
    seen = 1'b0;
    repeat (6) begin
      seen |= s;
      step();
    end
  endtask
  task automatic dll(input logic on, output int cyc);
    logic sr;
    sr = 1'b0;
    rdy();
    {dll_on_req, dll_off_req} = {on, !on};
    for (cyc = 0; cyc < 20 && busy !== 1'b1; cyc++) step();
    {dll_on_req, dll_off_req} = 2'b00;
    for (cyc = 0; cyc < 3000 && busy === 1'b1; cyc++) begin
      sr |= self_refresh;
      step();
    end
    chk(sr, "no self refresh during switch");
  endtask
  initial begin
    #40000;
    error_cnt++;
    $display("CHECK FAILED t=%0t watchdog expired", $time);
    results();
  end
  initial begin
    int lo, lf, n, auto_selfrefresh_enable, selfrefresh_temperature_range;
    logic [7:0] d;
    logic r;
    logic [1:0] wt;
    {req_valid, req_cmd, req_ba, req_addr} = '0;
    {dll_off_req, dll_on_req, zq_long} = 3'h0;
    repeat (12) @(posedge sys_clk);
    chk(dll_enabled === 1'b1 && link.cs_n === 1'b1, "reset");
    #1 reset_n = 1'b1;
    step();
    step();
    for (int i = 0; i < 4; i++) begin
      rnd = lfsr(rnd);
      {thermal_hot, wt} = rnd[2:0];
      auto_selfrefresh_enable = i % 2;
      selfrefresh_temperature_range = i / 2;
      req(3'h0, 3'h2, {2'b00, wt, 1'b0, i[1:0], 6'h0});
      rdy();
      n = (auto_selfrefresh_enable == 1) ? int'(thermal_hot) : selfrefresh_temperature_range;
      chk(sr_rate === 2'(n), "refresh rate");
      chk(write_term === wt, "write termination");
    end
    $display("test refresh rate done");
    req(3'h0, 3'h2, 13'h0600);
    req(3'h0, 3'h1, 13'h0080);
    rdy();
    chk(write_term === 2'b00, "leveling termination");
    req(3'h0, 3'h1, 13'h0000);
    rdy();
    chk(write_term === 2'b11, "termination restored");
    req(3'h4, 3'h0, 13'h0);
    chk(link.odt === 1'b1, "write termination strobe");
    $display("test termination done");
    rd(lo, d);
    chk(d === 8'h00, "array read");
    // Reserved address bits set on purpose; the controller must clear them
    req(3'h0, 3'h3, 13'h1ffc);
    rdy();
    chk(pattern_mode === 1'b1, "pattern on");
    rd(n, d);
    chk(d === 8'h55, "pattern read");
    req(3'h4, 3'h0, 13'h0);
    watch(req_refused, r);
    chk(r === 1'b1, "write refused");
    req(3'h0, 3'h3, 13'h0003);
    rdy();
    chk(pattern_mode === 1'b0, "pattern off");
    rd(n, d);
    chk(d === 8'h00, "array read again");
    req(3'h7, 3'h0, 13'h0);
    watch(cmd_seen, r);
    chk(r === 1'b0, "nop executed");
    req(3'h2, 3'h0, 13'h0);
    watch(cmd_seen, r);
    chk(r === 1'b1, "precharge seen");
    req(3'h0, 3'h3, 13'h0004);
    rdy();
    reset_n = 1'b0;
    step();
    chk(pattern_mode === 1'b0 && link.cs_n === 1'b1, "pattern reset");
    reset_n = 1'b1;
    step();
    step();
    $display("test pattern done");
    dll(1'b0, n);
    chk(dll_enabled === 1'b0, "dll off");
    rd(lf, d);
    chk(lf == int'(`CL_DLL_OFF), "dll off latency");
    chk(lf - lo == int'(`CL_DLL_OFF) - 1 - 4, "latency step");
    step();
    zq_long = 1'b1;
    step();
    zq_long = 1'b0;
    dll(1'b1, n);
    chk(dll_enabled === 1'b1, "dll on");
    chk(n >= `T_DLLK_CK + `T_ZQOPER_CK, "lock wait");
    $display("test dll switch done");
    results();
  end
endmodule
`default_nettype wire
